// ### src/nibble_skip_pkg.sv
// constants and types shared by the nibble/skip/table/xor execution block
package nibble_skip_pkg;
    // apb register byte offsets
    localparam logic [7:0] OFS_CMD   = 8'h00;
    localparam logic [7:0] OFS_WORK  = 8'h04;
    localparam logic [7:0] OFS_FLAGS = 8'h08;
    localparam logic [7:0] OFS_TPTR  = 8'h0c;
    localparam logic [7:0] OFS_THIGH = 8'h10;
    localparam logic [7:0] OFS_STAT  = 8'h14;
    localparam logic [7:0] OFS_PC    = 8'h18;
    // command word field positions
    localparam int CMD_OP_LSB   = 0;
    localparam int CMD_BIT_LSB  = 4;
    localparam int CMD_ADDR_LSB = 8;
    localparam int CMD_IMM_LSB  = 16;
    // flag bit positions
    localparam int FLAG_BORROW_INV = 0;
    localparam int FLAG_HALF       = 1;
    localparam int FLAG_NULL       = 2;
    localparam int FLAG_SIGNED     = 3;
    // status bit positions
    localparam int STAT_BUSY = 0;
    localparam int STAT_SKIP = 1;
    // reset values
    localparam logic [7:0]  WORK_RST  = 8'h00;
    localparam logic [3:0]  FLAGS_RST = 4'h0;
    localparam logic [7:0]  TPTR_RST  = 8'h00;
    localparam logic [7:0]  THIGH_RST = 8'h00;
    localparam logic [12:0] PC_RST    = 13'h0000;
    // program memory paging
    localparam logic [4:0]  LAST_PAGE = 5'h1f;
    localparam logic [12:0] PC_STEP   = 13'h0001;
    localparam logic [12:0] PC_SKIP   = 13'h0002;

    typedef enum logic [3:0] {
        OP_SUB_IMM  = 4'h0,
        OP_SWAP     = 4'h1,
        OP_SWAP_W   = 4'h2,
        OP_SKIP_Z   = 4'h3,
        OP_COPY_SKZ = 4'h4,
        OP_SKIP_BIT = 4'h5,
        OP_TBL_CUR  = 4'h6,
        OP_TBL_LAST = 4'h7,
        OP_XOR_W    = 4'h8,
        OP_XOR_M    = 4'h9,
        OP_XOR_IMM  = 4'ha
    } op_t;

    // gray codes along idle, fetch, exec, dummy
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_FETCH = 2'b01,
        ST_EXEC  = 2'b11,
        ST_DUMMY = 2'b10
    } state_t;
endpackage

// ### src/nibble_skip_exec.sv
// execution unit for nibble swap, zero skips, table reads, xor and subtract-immediate
// Notes on behaviour
// - subtract immediate from work register, update flags
// - borrow-inverse flag clear if negative, else set
// - swap memory nibbles in place, flags unchanged
// - swapped memory nibbles go to work register
// - skip next when memory byte is zero
// - copy byte to work register, skip if zero
// - skip next when selected memory bit clear
// - a skip that is taken takes two cycles, exec plus a dummy cycle
// - current-page table read: low to memory, high latched
// - last-page table read, same destinations, no flags
// - current-page read uses current page, no flags
// - xor memory into work register, null flag only
// - xor into memory location, null flag only
// - xor immediate into work register, null flag only
//
// The implementer's own choices: the APB register port and the register offsets.
`timescale 1ns/1ns
`default_nettype none
module nibble_skip_exec
    import nibble_skip_pkg::*;
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output var  logic [31:0] prdata,
    output var  logic        pready,
    output var  logic        pslverr,
    // data memory, synchronous read
    output var  logic [7:0]  dmAddr,
    output var  logic        dmWrite,
    output var  logic [7:0]  dmWdata,
    input  wire logic [7:0]  dmRdata,
    // program memory, synchronous read
    output var  logic [12:0] pmAddr,
    input  wire logic [15:0] pmRdata
);

    typedef struct packed {
        state_t      fsm;
        op_t         op;
        logic [2:0]  bitSel;
        logic [7:0]  imm;
        logic [7:0]  work;
        logic [3:0]  flags;
        logic [7:0]  tptr;
        logic [7:0]  thigh;
        logic [12:0] pc;
        logic        lastSkip;
        logic [7:0]  dmAddr;
        logic        dmWrite;
        logic [7:0]  dmWdata;
        logic [12:0] pmAddr;
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } regs_t;

    regs_t s;
    regs_t next_s;

    // address decode, used for the error answer
    function automatic logic isMapped(input logic [7:0] a);
        return a == OFS_CMD || a == OFS_WORK || a == OFS_FLAGS || a == OFS_TPTR
            || a == OFS_THIGH || a == OFS_STAT || a == OFS_PC;
    endfunction

    // opcodes that the unit knows; others are dropped at the command write
    function automatic logic isLegalOp(input logic [3:0] o);
        return o <= OP_XOR_IMM;
    endfunction

    logic [8:0] subFull;
    logic [4:0] subLow;
    logic [7:0] subRes;
    logic [7:0] xorMem;
    logic       apbWrite;

    // subtract-immediate arithmetic, borrow seen in the extra bit
    always_comb
    begin
        subFull  = {1'b0, s.work} - {1'b0, s.imm};
        subLow   = {1'b0, s.work[3:0]} - {1'b0, s.imm[3:0]};
        subRes   = subFull[7:0];
        xorMem   = s.work ^ dmRdata;
        apbWrite = psel && penable && s.pready && pwrite;
    end

    // next-state logic: apb first, execution afterwards so it wins on conflict
    always_comb
    begin
        next_s         = s;
        // answer fields stand for one cycle; a stale error would mislead the master
        next_s.pready  = 1'b0;
        next_s.pslverr = 1'b0;
        next_s.prdata  = 32'h0000_0000;
        next_s.dmWrite = 1'b0;

        // one wait cycle in every access keeps outputs registered
        if (psel && penable && !s.pready)
        begin
            next_s.pready  = 1'b1;
            next_s.pslverr = !isMapped(paddr);
            next_s.prdata  = 32'h0000_0000;
            unique case (paddr)
                OFS_WORK:  next_s.prdata[7:0]  = s.work;
                OFS_FLAGS: next_s.prdata[3:0]  = s.flags;
                OFS_TPTR:  next_s.prdata[7:0]  = s.tptr;
                OFS_THIGH: next_s.prdata[7:0]  = s.thigh;
                OFS_PC:    next_s.prdata[12:0] = s.pc;
                OFS_STAT:
                begin
                    next_s.prdata[STAT_BUSY] = s.fsm != ST_IDLE;
                    next_s.prdata[STAT_SKIP] = s.lastSkip;
                end
                default:   next_s.prdata = 32'h0000_0000;
            endcase
        end

        if (apbWrite)
        begin
            unique case (paddr)
                OFS_WORK:  next_s.work  = pwdata[7:0];
                OFS_FLAGS: next_s.flags = pwdata[3:0];
                OFS_TPTR:  next_s.tptr  = pwdata[7:0];
                OFS_PC:    next_s.pc    = pwdata[12:0];
                OFS_CMD:
                begin
                    // a command while busy is ignored, not queued
                    if (s.fsm == ST_IDLE && isLegalOp(pwdata[CMD_OP_LSB +: 4]))
                    begin
                        next_s.op     = op_t'(pwdata[CMD_OP_LSB +: 4]);
                        next_s.bitSel = pwdata[CMD_BIT_LSB +: 3];
                        next_s.imm    = pwdata[CMD_IMM_LSB +: 8];
                        next_s.dmAddr = pwdata[CMD_ADDR_LSB +: 8];
                        next_s.fsm    = ST_FETCH;
                        if (op_t'(pwdata[CMD_OP_LSB +: 4]) == OP_TBL_LAST)
                            next_s.pmAddr = {LAST_PAGE, s.tptr};
                        else
                            next_s.pmAddr = {s.pc[12:8], s.tptr};
                    end
                end
                default: ;
            endcase
        end

        unique case (s.fsm)
            ST_IDLE: ;
            // memories sample the address here; data is valid in exec
            ST_FETCH: next_s.fsm = ST_EXEC;
            ST_EXEC:
            begin
                next_s.lastSkip = 1'b0;
                unique case (s.op)
                    OP_SUB_IMM:
                    begin
                        next_s.work                   = subRes;
                        next_s.flags[FLAG_NULL]       = subRes == 8'h00;
                        next_s.flags[FLAG_HALF]       = !subLow[4];
                        next_s.flags[FLAG_BORROW_INV] = !subFull[8];
                        next_s.flags[FLAG_SIGNED]     = (s.work[7] ^ s.imm[7])
                                                      & (s.work[7] ^ subRes[7]);
                    end
                    OP_SWAP:
                    begin
                        next_s.dmWrite = 1'b1;
                        next_s.dmWdata = {dmRdata[3:0], dmRdata[7:4]};
                    end
                    OP_SWAP_W:   next_s.work = {dmRdata[3:0], dmRdata[7:4]};
                    OP_SKIP_Z:   next_s.lastSkip = dmRdata == 8'h00;
                    OP_COPY_SKZ:
                    begin
                        next_s.work     = dmRdata;
                        next_s.lastSkip = dmRdata == 8'h00;
                    end
                    OP_SKIP_BIT: next_s.lastSkip = !dmRdata[s.bitSel];
                    OP_TBL_CUR, OP_TBL_LAST:
                    begin
                        next_s.dmWrite = 1'b1;
                        next_s.dmWdata = pmRdata[7:0];
                        next_s.thigh   = pmRdata[15:8];
                    end
                    OP_XOR_W:
                    begin
                        next_s.work             = xorMem;
                        next_s.flags[FLAG_NULL] = xorMem == 8'h00;
                    end
                    OP_XOR_M:
                    begin
                        next_s.dmWrite          = 1'b1;
                        next_s.dmWdata          = xorMem;
                        next_s.flags[FLAG_NULL] = xorMem == 8'h00;
                    end
                    OP_XOR_IMM:
                    begin
                        next_s.work             = s.work ^ s.imm;
                        next_s.flags[FLAG_NULL] = (s.work ^ s.imm) == 8'h00;
                    end
                    default: ;
                endcase
                // a skip steps over the fetched word and burns a dummy cycle
                if (next_s.lastSkip)
                begin
                    next_s.pc  = s.pc + PC_SKIP;
                    next_s.fsm = ST_DUMMY;
                end
                else
                begin
                    next_s.pc  = s.pc + PC_STEP;
                    next_s.fsm = ST_IDLE;
                end
            end
            ST_DUMMY: next_s.fsm = ST_IDLE;
        endcase
    end

    // single state register
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            s          <= '0;
            s.fsm      <= ST_IDLE;
            s.op       <= OP_SUB_IMM;
            s.work     <= WORK_RST;
            s.flags    <= FLAGS_RST;
            s.tptr     <= TPTR_RST;
            s.thigh    <= THIGH_RST;
            s.pc       <= PC_RST;
        end
        else
        begin
            s <= next_s;
        end
    end

    // outputs straight from the state register
    always_comb
    begin
        prdata  = s.prdata;
        pready  = s.pready;
        pslverr = s.pslverr;
        dmAddr  = s.dmAddr;
        dmWrite = s.dmWrite;
        dmWdata = s.dmWdata;
        pmAddr  = s.pmAddr;
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    logic execNow;
    assign execNow = s.fsm == ST_EXEC;

    // execution results are checked one edge after the exec cycle

    a_sub_borrow: assert property (
        execNow && s.op == OP_SUB_IMM |=> s.flags[FLAG_BORROW_INV] == ($past(s.work) >= $past(s.imm)))
        else $error("borrow-inverse flag wrong after subtract");
    a_sub_result: assert property (
        execNow && s.op == OP_SUB_IMM |=> s.work == 8'($past(s.work) - $past(s.imm)))
        else $error("subtract result wrong");
    a_swap_inplace: assert property (
        execNow && s.op == OP_SWAP |=> dmWrite && dmWdata == {$past(dmRdata[3:0]),
        $past(dmRdata[7:4])} && $stable(s.flags))
        else $error("in-place swap wrong");
    a_swap_work: assert property (
        execNow && s.op == OP_SWAP_W |=> !dmWrite && s.work[3:0] == $past(dmRdata[7:4])
        && s.work[7:4] == $past(dmRdata[3:0]) && $stable(s.flags))
        else $error("swap to work register wrong");
    a_skip_zero: assert property (
        execNow && s.op == OP_SKIP_Z && dmRdata == 8'h00 |=> s.pc == 13'($past(s.pc) + 2))
        else $error("zero byte did not skip");
    a_copy_skip: assert property (
        execNow && s.op == OP_COPY_SKZ |=> s.work == $past(dmRdata)
        && s.lastSkip == ($past(dmRdata) == 8'h00))
        else $error("copy-then-skip wrong");
    a_bit_skip: assert property (
        execNow && s.op == OP_SKIP_BIT |=> s.lastSkip == !$past(dmRdata[s.bitSel]))
        else $error("bit skip decision wrong");
    a_skip_twocyc: assert property (
        execNow && next_s.lastSkip |=> s.fsm == ST_DUMMY ##1 s.fsm == ST_IDLE)
        else $error("skip did not take a dummy cycle");
    a_table_page: assert property (
        s.fsm == ST_FETCH && s.op == OP_TBL_CUR |-> pmAddr == {s.pc[12:8], s.tptr})
        else $error("current-page table address wrong");
    a_table_last: assert property (
        s.fsm == ST_FETCH && s.op == OP_TBL_LAST |-> pmAddr[12:8] == LAST_PAGE
        ##1 1'b1 ##1 s.thigh == $past(pmRdata[15:8]) && dmWdata == $past(pmRdata[7:0]))
        else $error("last-page table read wrong");
    a_xor_null: assert property (
        execNow && s.op == OP_XOR_W |=> s.work == ($past(s.work) ^ $past(dmRdata))
        && s.flags[FLAG_NULL] == (s.work == 8'h00) && s.flags[1:0] == $past(s.flags[1:0])
        && s.flags[FLAG_SIGNED] == $past(s.flags[FLAG_SIGNED]))
        else $error("xor into work register wrong");
    a_exclusive_or_to_memory_write: assert property (
        execNow && s.op == OP_XOR_M |=> dmWrite && dmWdata == ($past(s.work) ^ $past(dmRdata))
        && s.flags[FLAG_NULL] == (dmWdata == 8'h00) && s.work == $past(s.work))
        else $error("xor into memory wrong");
    a_xor_imm: assert property (
        execNow && s.op == OP_XOR_IMM |=> s.work == ($past(s.work) ^ $past(s.imm))
        && s.flags[FLAG_NULL] == (s.work == 8'h00))
        else $error("xor immediate wrong");
    a_step_noskip: assert property (
        execNow && !next_s.lastSkip |=> s.pc == 13'($past(s.pc) + 1) && s.fsm == ST_IDLE)
        else $error("counter step wrong");
    a_dummy_quiet: assert property (
        s.fsm == ST_DUMMY && !apbWrite |=> $stable(s.work) && $stable(s.flags) && $stable(s.pc))
        else $error("discarded word changed state");

    // ops with no flag effect leave every flag alone
    a_flags_kept: assert property (
        execNow && s.op inside {OP_SWAP, OP_SWAP_W, OP_SKIP_Z, OP_COPY_SKZ, OP_SKIP_BIT,
        OP_TBL_CUR, OP_TBL_LAST} |=> $stable(s.flags))
        else $error("flags changed by a flag-free op");

    // table data and memory write discipline
    a_table_cur: assert property (
        s.fsm == ST_FETCH && s.op == OP_TBL_CUR |-> ##2 dmWrite
        && s.thigh == $past(pmRdata[15:8]) && dmWdata == $past(pmRdata[7:0]))
        else $error("current-page table data wrong");
    a_mem_quiet: assert property (
        dmWrite |-> $past(execNow) && $past(s.op) inside {OP_SWAP, OP_TBL_CUR, OP_TBL_LAST,
        OP_XOR_M})
        else $error("data memory written by a read-only op");
    a_cmd_addr: assert property (
        s.fsm == ST_FETCH |-> dmAddr == $past(pwdata[CMD_ADDR_LSB +: 8]))
        else $error("data address not taken from the command");

    // register bus answers after exactly one wait cycle, error only off the map
    a_ready_wait: assert property (
        psel && penable && !pready |=> pready)
        else $error("register bus answer late");
    a_err_decode: assert property (
        pready |-> pslverr == !isMapped($past(paddr)))
        else $error("bus error flag wrong");

    // main scenarios worth seeing
    c_skip_taken: cover property (s.fsm == ST_DUMMY);
    c_table_read: cover property (execNow && s.op == OP_TBL_LAST);
    c_sub_neg:    cover property (execNow && s.op == OP_SUB_IMM && subFull[8]);
    c_bad_addr:   cover property (pready && pslverr);
    c_bit_keep:   cover property (execNow && s.op == OP_SKIP_BIT && dmRdata[s.bitSel]);

endmodule
`default_nettype wire

// ### verif/tb_top.sv
// self-checking testbench for the nibble/skip/table/xor execution block
`timescale 1ns/1ns
`default_nettype none
module tb_top
    import nibble_skip_pkg::*;
;
    logic        clk = 1'b0;
    logic        rst;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [7:0]  dmAddr;
    logic        dmWrite;
    logic [7:0]  dmWdata;
    logic [7:0]  dmRdata;
    logic [12:0] pmAddr;
    logic [15:0] pmRdata;
    logic [7:0]  dm [0:255];
    logic [15:0] pm [0:8191];
    logic [31:0] r;
    logic        e;
    logic [12:0] pcExp;
    int          numErrors;
    int          checkCount;
    logic [7:0]  sw [4] = '{8'h05, 8'h07, 8'h80, 8'h13};
    logic [7:0]  sx [4] = '{8'h07, 8'h07, 8'h01, 8'h04};

    nibble_skip_exec u_nibble_skip_exec (
        .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .dmAddr(dmAddr), .dmWrite(dmWrite), .dmWdata(dmWdata),
        .dmRdata(dmRdata), .pmAddr(pmAddr), .pmRdata(pmRdata)
    );

    // free-running 50 MHz clock
    always #10 clk = ~clk;

    // synchronous memories: read data shows one edge after the address
    always @(posedge clk)
    begin
        if (dmWrite === 1'b1)
            dm[dmAddr] <= dmWdata;
        dmRdata <= dm[dmAddr];
        pmRdata <= pm[pmAddr];
    end

    task automatic wrapUp;
        if (numErrors == 0 && checkCount > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checkCount++;
        if (seen !== exp)
        begin
            numErrors++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // one apb transfer, begun just after a rising edge; answer taken at the edge where
    // pready is high, then one idle edge so the next call never re-drives psel at once
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic er);
        int n;
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        if (n >= 20)
        begin
            numErrors++;
            wrapUp;
        end
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, r, e);
    endtask

    task automatic rdChk(input string name, input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0, r, e);
        chk(name, r, exp);
    endtask

    task automatic prep(input logic [7:0] w, input logic [3:0] f);
        wr(OFS_WORK, 32'(w));
        wr(OFS_FLAGS, 32'(f));
    endtask

    // issue a command, poll busy under a bound, then compare the visible state
    task automatic runOp(input logic [3:0] op, input logic [2:0] b, input logic [7:0] a,
                         input logic [7:0] imm, input logic [7:0] ew, input logic [3:0] ef,
                         input logic sk);
        int n;
        wr(OFS_CMD, {8'h00, imm, a, 1'b0, b, op});
        n = 0;
        do
        begin
            apb(1'b0, OFS_STAT, 32'h0, r, e);
            if (n == 0)
                chk("busy after exec", 32'(r[STAT_BUSY]), 32'(sk));
            n++;
        end
        while (r[STAT_BUSY] !== 1'b0 && n < 20);
        if (n >= 20)
        begin
            numErrors++;
            wrapUp;
        end
        chk("skip status", 32'(r[STAT_SKIP]), 32'(sk));
        pcExp = pcExp + (sk ? PC_SKIP : PC_STEP);
        rdChk("work register", OFS_WORK, 32'(ew));
        rdChk("flags", OFS_FLAGS, 32'(ef));
        rdChk("program counter", OFS_PC, 32'(pcExp));
    endtask

    // expected flags of a subtraction: signed, null, half-borrow, borrow-inverse
    function automatic logic [3:0] subFlags(input logic [7:0] w, input logic [7:0] x);
        logic [7:0] d;
        d = w - x;
        return {(w[7] != x[7]) && (d[7] != w[7]), d == 8'h00, w[3:0] >= x[3:0], w >= x};
    endfunction

    initial
    begin
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        numErrors = 0;
        checkCount = 0;
        pcExp = 13'h0000;
        for (int i = 0; i < 256; i++)
            dm[i] = 8'h00;
        for (int i = 0; i < 8192; i++)
            pm[i] = 16'h0000;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        // reset values, unmapped access and a read-only latch
        for (int a = 4; a <= 24; a += 4)
            rdChk("reset value", 8'(a), 32'h0);
        apb(1'b0, 8'h1c, 32'h0, r, e);
        chk("unmapped error", 32'(e), 32'h1);
        chk("unmapped data", r, 32'h0);
        wr(OFS_THIGH, 32'hff);
        rdChk("read-only latch", OFS_THIGH, 32'h0);
        // subtract immediate: negative, zero, overflow and half-borrow cases
        for (int i = 0; i < 4; i++)
        begin
            prep(sw[i], 4'h0);
            runOp(OP_SUB_IMM, 3'h0, 8'h00, sx[i], sw[i] - sx[i], subFlags(sw[i], sx[i]), 1'b0);
        end
        // nibble exchange; flags preset to a mixed pattern that must survive
        dm[8'h21] = 8'h3c;
        dm[8'h22] = 8'h5a;
        prep(8'h11, 4'hb);
        runOp(OP_SWAP, 3'h0, 8'h21, 8'h00, 8'h11, 4'hb, 1'b0);
        chk("swapped byte", 32'(dm[8'h21]), 32'hc3);
        runOp(OP_SWAP_W, 3'h0, 8'h22, 8'h00, 8'ha5, 4'hb, 1'b0);
        chk("source byte", 32'(dm[8'h22]), 32'h5a);
        // skips on byte, copy and bit, both outcomes and bit boundaries
        dm[8'h30] = 8'h00;
        dm[8'h31] = 8'h10;
        dm[8'h32] = 8'hfe;
        runOp(OP_SKIP_Z, 3'h0, 8'h30, 8'h00, 8'ha5, 4'hb, 1'b1);
        runOp(OP_SKIP_Z, 3'h0, 8'h31, 8'h00, 8'ha5, 4'hb, 1'b0);
        runOp(OP_COPY_SKZ, 3'h0, 8'h31, 8'h00, 8'h10, 4'hb, 1'b0);
        runOp(OP_COPY_SKZ, 3'h0, 8'h30, 8'h00, 8'h00, 4'hb, 1'b1);
        runOp(OP_SKIP_BIT, 3'h0, 8'h32, 8'h00, 8'h00, 4'hb, 1'b1);
        runOp(OP_SKIP_BIT, 3'h7, 8'h32, 8'h00, 8'h00, 4'hb, 1'b0);
        runOp(OP_SKIP_BIT, 3'h1, 8'h32, 8'h00, 8'h00, 4'hb, 1'b0);
        // table reads from page 3 and from the last page at the same offset
        pm[13'h0012] = 16'h1111;
        pm[13'h0312] = 16'hbeef;
        pm[13'h1f12] = 16'hcafe;
        wr(OFS_PC, 32'h0345);
        pcExp = 13'h0345;
        wr(OFS_TPTR, 32'h12);
        runOp(OP_TBL_CUR, 3'h0, 8'h40, 8'h00, 8'h00, 4'hb, 1'b0);
        chk("table low byte", 32'(dm[8'h40]), 32'hef);
        rdChk("table high byte", OFS_THIGH, 32'hbe);
        runOp(OP_TBL_LAST, 3'h0, 8'h41, 8'h00, 8'h00, 4'hb, 1'b0);
        chk("last page low byte", 32'(dm[8'h41]), 32'hfe);
        rdChk("last page high byte", OFS_THIGH, 32'hca);
        // exclusive-or: null flag set and cleared, other flags kept
        dm[8'h50] = 8'h5a;
        dm[8'h51] = 8'hf0;
        prep(8'h5a, 4'hb);
        runOp(OP_XOR_W, 3'h0, 8'h50, 8'h00, 8'h00, 4'hf, 1'b0);
        prep(8'h0f, 4'hf);
        runOp(OP_XOR_M, 3'h0, 8'h51, 8'h00, 8'h0f, 4'hb, 1'b0);
        chk("xor result in memory", 32'(dm[8'h51]), 32'hff);
        runOp(OP_XOR_IMM, 3'h0, 8'h00, 8'h0f, 8'h00, 4'hf, 1'b0);
        // an unknown opcode is dropped: nothing runs and the counter stays put
        wr(OFS_CMD, 32'h0000_000b);
        rdChk("unknown op ignored", OFS_PC, 32'(pcExp));
        wrapUp;
    end
endmodule
`default_nettype wire
